// File: fom_core.sv
// Contract
// (RQ1) Bit rate: crystal over divider plus fraction/16
// (RQ2) OOK ignores fraction, treated as zero
// (RQ3) Host data async; aligned to bit clock when Gaussian
// (RQ4) Deviation equals step times 14-bit word
// (RQ5) Software keeps deviation in legal range
// (RQ6) OOK switches amplifier on and off
// (RQ7) FSK shaping uses Gaussian BT 0.5 or 1
// (RQ8) Bit clock edge per needed transmit bit
// (RQ9) OOK shaping ramps amplifier up and down
// (RQ10) Restart transmitter after shaping change
// (RQ11) Receive data routed through bit synchronizer
// (RQ12) Software keeps modulation index 0.5 to 10
// (RQ13) OOK decision against one of three thresholds
// (RQ14) Peak mode threshold is peak minus 6dB
// (RQ15) Peak decays by step every decay period
// (RQ16) Decay stops at floor threshold
// (RQ17) Fixed mode compares against floor threshold
// (RQ18) Average mode compares against sample average
// (RQ19) Larger sample loads peak immediately
// (RQ20) Fractional accumulator counter emits bit tick
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "fom_cfg.svh"

module fom_core
    import fom_pkg::*;
(
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // APB slave
    input  wire fom_apb_req_t apb_req,
    output var  fom_apb_rsp_t apb_rsp,
    // Serial link to host
    input  wire logic         serial_data_pin_in,
    output var  logic         serial_data_pin_out,
    output var  logic         serial_data_pin_oe_n,
    output var  logic         bit_clock_out,
    // Radio front end
    input  wire logic [7:0]   rssi_sample,
    output var  logic signed [15:0] synth_frac_offset,
    output var  logic [7:0]   pa_bias_level
);

    fom_state_t st_reg;
    fom_state_t st_next;

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    function automatic logic [31:0] read_word(input fom_state_t s, input logic [11:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            `FOM_OFF_RATE_HIGH: w[7:0] = s.cfg.rate_div[15:8];
            `FOM_OFF_RATE_LOW:  w[7:0] = s.cfg.rate_div[7:0];
            `FOM_OFF_RATE_FRAC: w[3:0] = s.cfg.frac;
            `FOM_OFF_DEV:       w[13:0] = s.cfg.dev;
            `FOM_OFF_MODE:      w[3:0] = {s.cfg.sync_on, s.cfg.tx_on, s.cfg.cont, s.cfg.ook};
            `FOM_OFF_RAMP:      w[5:0] = {s.cfg.shape, s.ramp_step};
            `FOM_OFF_PEAK:      w[7:0] = {s.cfg.thr_kind, s.cfg.decay_step, s.cfg.decay_period};
            `FOM_OFF_FLOOR:     w[7:0] = s.cfg.floor;
            `FOM_OFF_STATUS:    w[18:0] = {s.pa_on, s.rx_bit, s.tx_bit, s.pa_level, s.peak};
            default:            w = 32'h0000_0000;
        endcase
        return w;
    endfunction : read_word

    function automatic logic addr_ok(input logic [11:0] a);
        return (a[1:0] == 2'b00) && (a <= `FOM_OFF_STATUS);
    endfunction : addr_ok

    // Saturating subtract used by threshold and decay paths
    function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? (a - b) : 8'h00;
    endfunction : sat_sub

    logic [20:0] period_x16;
    logic [7:0]  threshold;
    logic [7:0]  decay_len;
    logic [7:0]  decay_amt;
    logic        gauss_mode;

    always_comb begin
        st_next = st_reg;
        period_x16 = 21'h0;
        threshold = 8'h00;
        decay_len = 8'h00;
        decay_amt = 8'h00;
        gauss_mode = 1'b0;

        // --------------------------------------------------------
        // APB slave, one wait state
        // --------------------------------------------------------
        st_next.rsp.pready  = 1'b0;
        st_next.rsp.pslverr = 1'b0;
        case (st_reg.apb_st)
            FOM_APB_IDLE: begin
                if (apb_req.psel && !apb_req.penable) begin
                    st_next.apb_st = FOM_APB_ACCESS;
                end
            end
            FOM_APB_ACCESS: begin
                if (!st_reg.rsp.pready) begin
                    st_next.rsp.pready  = 1'b1;
                    st_next.rsp.pslverr = !addr_ok(apb_req.paddr);
                    st_next.rsp.prdata  = apb_req.pwrite ? 32'h0 : read_word(st_reg, apb_req.paddr);
                    if (apb_req.pwrite) begin
                        case (apb_req.paddr)
                            `FOM_OFF_RATE_HIGH: st_next.cfg.rate_div[15:8] = apb_req.pwdata[7:0];
                            `FOM_OFF_RATE_LOW:  st_next.cfg.rate_div[7:0] = apb_req.pwdata[7:0];
                            `FOM_OFF_RATE_FRAC: st_next.cfg.frac = apb_req.pwdata[3:0];
                            `FOM_OFF_DEV:       st_next.cfg.dev = apb_req.pwdata[13:0];
                            `FOM_OFF_MODE: begin
                                st_next.cfg.ook     = apb_req.pwdata[`FOM_MODE_OOK_BIT];
                                st_next.cfg.cont    = apb_req.pwdata[`FOM_MODE_CONT_BIT];
                                st_next.cfg.tx_on   = apb_req.pwdata[`FOM_MODE_TX_BIT];
                                st_next.cfg.sync_on = apb_req.pwdata[`FOM_MODE_SYNC_BIT];
                            end
                            `FOM_OFF_RAMP: begin
                                st_next.ramp_step = apb_req.pwdata[3:0];
                                st_next.cfg.shape = fom_shape_t'(apb_req.pwdata[5:4]);
                            end
                            `FOM_OFF_PEAK: begin
                                st_next.cfg.decay_period = apb_req.pwdata[2:0];
                                st_next.cfg.decay_step   = apb_req.pwdata[5:3];
                                st_next.cfg.thr_kind     = fom_thr_t'(apb_req.pwdata[7:6]);
                            end
                            `FOM_OFF_FLOOR: st_next.cfg.floor = apb_req.pwdata[7:0];
                            default: ;
                        endcase
                    end
                end else begin
                    st_next.apb_st = FOM_APB_IDLE;
                end
            end
            default: st_next.apb_st = FOM_APB_IDLE;
        endcase

        // --------------------------------------------------------
        // Bit-rate generator
        // --------------------------------------------------------
        period_x16 = {1'b0, st_reg.cfg.rate_div, 4'h0} +
                     {17'h0, (st_reg.cfg.ook ? 4'h0 : st_reg.cfg.frac)}; // RQ1 RQ2
        st_next.tick = 1'b0;
        if (st_reg.rate_cnt + 21'd16 >= period_x16) begin // RQ20
            st_next.rate_cnt = st_reg.rate_cnt + 21'd16 - period_x16;
            st_next.tick = 1'b1;
        end else begin
            st_next.rate_cnt = st_reg.rate_cnt + 21'd16;
        end

        gauss_mode = !st_reg.cfg.ook && (st_reg.cfg.shape != FOM_SHAPE_NONE);

        // --------------------------------------------------------
        // Bit clock and transmit data
        // --------------------------------------------------------
        st_next.tx_sync = {st_reg.tx_sync[0], serial_data_pin_in};
        if (st_reg.tick) begin
            st_next.bit_clk = 1'b0;
        end else if (st_reg.rate_cnt >= {1'b0, period_x16[20:1]}) begin
            st_next.bit_clk = 1'b1;
        end
        if (st_reg.cfg.tx_on) begin
            if (st_reg.cfg.cont && !gauss_mode) begin
                st_next.tx_bit = st_reg.tx_sync[1]; // RQ3
            end else if (st_reg.tick) begin
                st_next.tx_bit = st_reg.tx_sync[1]; // RQ3 RQ8
            end
        end else begin
            st_next.tx_bit = 1'b0;
        end

        // --------------------------------------------------------
        // FSK deviation with optional Gaussian shaping
        // --------------------------------------------------------
        if (st_reg.tick) begin
            st_next.gauss_hist = {st_reg.gauss_hist[2:0], st_reg.tx_bit};
        end
        if (!st_reg.cfg.tx_on || st_reg.cfg.ook) begin
            st_next.mod_word = 16'sh0000;
        end else if (st_reg.cfg.shape == FOM_SHAPE_BT05) begin
            // Taps 1-3-3-1 over the last four bits, weight sum 8
            st_next.mod_word = 16'($signed({2'b00, st_reg.cfg.dev}) *
                (($signed({1'b0, st_reg.gauss_hist[3]}) + 3 * $signed({1'b0, st_reg.gauss_hist[2]}) +
                  3 * $signed({1'b0, st_reg.gauss_hist[1]}) + $signed({1'b0, st_reg.gauss_hist[0]})) * 2 - 8)
                >>> 3); // RQ7 RQ4
        end else if (st_reg.cfg.shape == FOM_SHAPE_BT10) begin
            // Taps 1-2-1 over the last three bits, weight sum 4
            st_next.mod_word = 16'($signed({2'b00, st_reg.cfg.dev}) *
                (($signed({1'b0, st_reg.gauss_hist[2]}) + 2 * $signed({1'b0, st_reg.gauss_hist[1]}) +
                  $signed({1'b0, st_reg.gauss_hist[0]})) * 2 - 4)
                >>> 2); // RQ7 RQ4
        end else begin
            st_next.mod_word = st_reg.tx_bit ? $signed({2'b00, st_reg.cfg.dev})
                                             : -$signed({2'b00, st_reg.cfg.dev}); // RQ4
        end

        // --------------------------------------------------------
        // OOK amplifier control
        // --------------------------------------------------------
        st_next.pa_on = st_reg.cfg.tx_on && st_reg.cfg.ook && st_reg.tx_bit; // RQ6
        if (st_reg.cfg.shape == FOM_SHAPE_NONE || !st_reg.cfg.ook) begin
            st_next.pa_level = st_reg.pa_on ? `FOM_RSSI_MAX : 8'h00; // RQ6
        end else if (st_reg.pa_on) begin
            st_next.pa_level = (st_reg.pa_level > 8'(`FOM_RSSI_MAX - {4'h0, st_reg.ramp_step}))
                             ? `FOM_RSSI_MAX : st_reg.pa_level + {4'h0, st_reg.ramp_step} + 8'h01; // RQ9
        end else begin
            st_next.pa_level = sat_sub(st_reg.pa_level, {4'h0, st_reg.ramp_step} + 8'h01); // RQ9
        end

        // --------------------------------------------------------
        // OOK demodulator threshold
        // --------------------------------------------------------
        st_next.avg_acc = st_reg.avg_acc - {4'h0, st_reg.avg_acc[11:4]} + {4'h0, rssi_sample};
        decay_len = 8'h01 << st_reg.cfg.decay_period;
        decay_amt = {5'h00, st_reg.cfg.decay_step} + 8'h01;
        case (st_reg.cfg.thr_kind)
            FOM_THR_PEAK:  threshold = sat_sub(st_reg.peak, `FOM_PEAK_DROP_6DB); // RQ14
            FOM_THR_AVG:   threshold = st_reg.avg_acc[11:4]; // RQ18
            default:       threshold = st_reg.cfg.floor; // RQ17
        endcase
        if (threshold < st_reg.cfg.floor) begin
            threshold = st_reg.cfg.floor;
        end
        st_next.rx_bit = rssi_sample > threshold; // RQ13
        if (rssi_sample > st_reg.peak) begin
            st_next.peak = rssi_sample; // RQ19
            st_next.decay_cnt = 8'h00;
        end else if (!st_reg.rx_bit) begin
            if (st_reg.decay_cnt + 8'h01 >= decay_len) begin
                st_next.decay_cnt = 8'h00;
                st_next.peak = (sat_sub(st_reg.peak, decay_amt) < st_reg.cfg.floor)
                             ? st_reg.cfg.floor : sat_sub(st_reg.peak, decay_amt); // RQ15 RQ16
            end else begin
                st_next.decay_cnt = st_reg.decay_cnt + 8'h01;
            end
        end

        // --------------------------------------------------------
        // Receive path toward the host
        // --------------------------------------------------------
        st_next.rx_sync = {st_reg.rx_sync[0], st_reg.rx_bit};
        if (!st_reg.cfg.sync_on) begin
            st_next.rx_data = st_reg.rx_bit;
        end else if (st_reg.tick) begin
            st_next.rx_data = st_reg.rx_sync[1]; // RQ11
        end
        if (st_reg.cfg.sync_on && (st_reg.rx_sync[1] != st_reg.rx_sync[0])) begin
            st_next.rate_cnt = 21'h0; // RQ11
        end
        st_next.rx_clk = st_reg.bit_clk;

        if (!rst_n) begin
            st_next = '0;
            st_next.cfg.rate_div     = {`FOM_RST_RATE_HIGH, `FOM_RST_RATE_LOW};
            st_next.cfg.dev          = `FOM_RST_DEV;
            st_next.cfg.floor        = `FOM_RST_FLOOR;
            st_next.cfg.thr_kind     = FOM_THR_PEAK;
            st_next.cfg.decay_step   = `FOM_RST_DECAY_STEP;
            st_next.cfg.decay_period = `FOM_RST_DECAY_PER;
            st_next.ramp_step        = `FOM_RST_RAMP_STEP;
            st_next.apb_st           = FOM_APB_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_reg <= st_next;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        apb_rsp              = st_reg.rsp;
        bit_clock_out        = st_reg.bit_clk;
        serial_data_pin_out  = st_reg.rx_data;
        serial_data_pin_oe_n = st_reg.cfg.tx_on;
        synth_frac_offset    = st_reg.mod_word;
        pa_bias_level        = st_reg.pa_level;
    end

endmodule : fom_core
`default_nettype wire

// File: fom_cfg.svh
`ifndef FOM_CFG_SVH
`define FOM_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FOM_OFF_RATE_HIGH   12'h000
`define FOM_OFF_RATE_LOW    12'h004
`define FOM_OFF_RATE_FRAC   12'h008
`define FOM_OFF_DEV         12'h00c
`define FOM_OFF_MODE        12'h010
`define FOM_OFF_RAMP        12'h014
`define FOM_OFF_PEAK        12'h018
`define FOM_OFF_FLOOR       12'h01c
`define FOM_OFF_STATUS      12'h020

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FOM_RST_RATE_HIGH   8'h1a
`define FOM_RST_RATE_LOW    8'h0b
`define FOM_RST_DEV         14'h0052
`define FOM_RST_FLOOR       8'h0c
`define FOM_RST_DECAY_STEP  3'h0
`define FOM_RST_DECAY_PER   3'h0
`define FOM_RST_RAMP_STEP   4'h9

// ----------------------------------------------------------------
// Field positions and constants
// ----------------------------------------------------------------
`define FOM_MODE_OOK_BIT    0
`define FOM_MODE_CONT_BIT   1
`define FOM_MODE_TX_BIT     2
`define FOM_MODE_SYNC_BIT   3
`define FOM_FRAC_DEN        8'd16
`define FOM_PEAK_DROP_6DB   8'd12
`define FOM_RSSI_MAX        8'hff

`endif

// File: fom_pkg.sv
package fom_pkg;

    typedef enum logic [1:0] {
        FOM_SHAPE_NONE,
        FOM_SHAPE_BT10,
        FOM_SHAPE_BT05,
        FOM_SHAPE_RSVD
    } fom_shape_t;

    typedef enum logic [1:0] {
        FOM_THR_FIXED,
        FOM_THR_PEAK,
        FOM_THR_AVG,
        FOM_THR_RSVD
    } fom_thr_t;

    typedef enum {
        FOM_APB_IDLE,
        FOM_APB_ACCESS
    } fom_apb_st_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } fom_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } fom_apb_rsp_t;

    typedef struct packed {
        logic [15:0] rate_div;
        logic [3:0]  frac;
        logic [13:0] dev;
        logic        ook;
        logic        cont;
        logic        tx_on;
        logic        sync_on;
        fom_shape_t  shape;
        fom_thr_t    thr_kind;
        logic [2:0]  decay_step;
        logic [2:0]  decay_period;
        logic [7:0]  floor;
    } fom_cfg_t;

    typedef struct packed {
        fom_apb_st_t  apb_st;
        fom_apb_rsp_t rsp;
        fom_cfg_t     cfg;
        logic [3:0]   ramp_step;
        logic [20:0]  rate_cnt;
        logic         tick;
        logic         bit_clk;
        logic [1:0]   tx_sync;
        logic         tx_bit;
        logic [3:0]   gauss_hist;
        logic signed [15:0] mod_word;
        logic [7:0]   pa_level;
        logic         pa_on;
        logic [7:0]   peak;
        logic [11:0]  avg_acc;
        logic [7:0]   decay_cnt;
        logic         rx_bit;
        logic         rx_data;
        logic         rx_clk;
        logic [1:0]   rx_sync;
    } fom_state_t;

endpackage : fom_pkg

// File: fom_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// --------
// Port checker
// --------
module fom_monitor
    import fom_pkg::*;
(
    // Clock and reset
    input wire logic                sys_clk,
    input wire logic                rst_n,
    // Register bus
    input wire fom_apb_req_t        apb_req,
    input wire fom_apb_rsp_t        apb_rsp,
    // Link and front end
    input wire logic                serial_data_pin_in,
    input wire logic                serial_data_pin_out,
    input wire logic                serial_data_pin_oe_n,
    input wire logic                bit_clock_out,
    input wire logic [7:0]          rssi_sample,
    input wire logic signed [15:0]  synth_frac_offset,
    input wire logic [7:0]          pa_bias_level
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ready_after_setup_a: assert property (apb_req.psel && !apb_req.penable |-> ##[1:3] apb_rsp.pready)
        else $error("no answer after setup");
    ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    ready_in_access_a: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
        else $error("pready outside access phase");
    err_with_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("pslverr without pready");
    err_reads_zero_a: assert property (apb_rsp.pready && apb_rsp.pslverr && !apb_req.pwrite |-> apb_rsp.prdata == 0)
        else $error("refused read returned data");
    rdata_hold_a: assert property (!apb_rsp.pready |-> $stable(apb_rsp.prdata))
        else $error("prdata changed between answers");
    reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> pa_bias_level == 0 && synth_frac_offset == 0
        && !bit_clock_out && !serial_data_pin_oe_n && !apb_rsp.pready)
        else $error("outputs not quiet in reset");
    bitclk_low_a: assert property ($fell(bit_clock_out) |=> !bit_clock_out)
        else $error("bit clock low for one cycle only");
    pa_off_rx_a: assert property (!serial_data_pin_oe_n |-> pa_bias_level == 0)
        else $error("amplifier on while receiving");

    cover property (apb_rsp.pslverr);
    cover property ($fell(bit_clock_out));
    cover property (pa_bias_level == 8'hff);
endmodule : fom_monitor

bind fom_core fom_monitor i_fom_monitor (.sys_clk, .rst_n, .apb_req, .apb_rsp, .serial_data_pin_in,
    .serial_data_pin_out, .serial_data_pin_oe_n, .bit_clock_out, .rssi_sample, .synth_frac_offset,
    .pa_bias_level);
`default_nettype wire

// File: fom_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// --------
// Host serial source
// --------
module fom_host_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Bench control
    input  wire logic       align,
    input  wire logic [7:0] pattern,
    // Link
    input  wire logic       bit_clock_out,
    output var  logic       data_out
);
    logic       clk_q;
    logic [2:0] idx;

    // Next bit is presented just after the bit clock falls
    always_ff @(posedge sys_clk) begin
        clk_q <= bit_clock_out;
        if (!rst_n)
            idx <= 3'h7;
        else if (clk_q && !bit_clock_out)
            idx <= idx - 3'h1;
    end

    assign data_out = align ? pattern[idx] : pattern[7];
endmodule : fom_host_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "fom_cfg.svh"
module testbench
    import fom_pkg::*;
;
    logic               sys_clk = 1'b0;
    logic               rst_n = 1'b0;
    fom_apb_req_t       apb_req = '0;
    fom_apb_rsp_t       apb_rsp;
    logic               host_d, pin, dev_out, oe_n, bclk, err;
    logic               align = 1'b0;
    logic [7:0]         pattern = 8'h00;
    logic [7:0]         rssi = 8'h00;
    logic [7:0]         pa;
    logic signed [15:0] synth;
    logic [31:0]        rd;
    int                 error_cnt = 0;
    int                 total_checks = 0;

    always #4 sys_clk = ~sys_clk;

    fom_core i_fom_core (.sys_clk, .rst_n, .apb_req, .apb_rsp, .serial_data_pin_in(pin),
        .serial_data_pin_out(dev_out), .serial_data_pin_oe_n(oe_n), .bit_clock_out(bclk),
        .rssi_sample(rssi), .synth_frac_offset(synth), .pa_bias_level(pa));
    fom_host_model i_fom_host_model (.sys_clk, .rst_n, .align, .pattern, .bit_clock_out(bclk),
        .data_out(host_d));
    // Device owns the pin while receiving
    assign pin = oe_n ? host_d : dev_out;

    // --------
    // Common tasks
    // --------
    task automatic results;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tmo(input string name);
        error_cnt++;
        $display("[FAIL] %s expected done seen timeout", name);
        results();
    endtask : tmo

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        // Look at the answer mid-cycle, then release after the edge that samples it
        do begin
            @(negedge sys_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (n >= 20)
            tmo("apb");
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        @(posedge sys_clk);
        apb_req <= '0;
        @(posedge sys_clk);
    endtask : apb

    task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask : rchk

    // Cycles spanned by two bit periods
    task automatic meas(output int c);
        int   f;
        int   n;
        logic p;
        c = 0;
        f = 0;
        n = 0;
        p = bclk;
        while (f < 3 && n < 400) begin
            @(negedge sys_clk);
            n++;
            if (f > 0)
                c++;
            if (p && !bclk)
                f++;
            p = bclk;
        end
        if (f < 3)
            tmo("bit_clock");
        @(posedge sys_clk);
    endtask : meas

    // --------
    // Scenarios
    // --------
    task automatic t_regs;
        rchk("rate_high", `FOM_OFF_RATE_HIGH, 32'h1a);
        rchk("rate_low", `FOM_OFF_RATE_LOW, 32'h0b);
        rchk("deviation", `FOM_OFF_DEV, 32'h52);
        rchk("floor", `FOM_OFF_FLOOR, 32'h0c);
        apb(1'b0, 12'h024, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        apb(1'b1, 12'h006, 32'h5);
        chk("misaligned_err", 32'h1, {31'h0, err});
    endtask : t_regs

    task automatic t_dev;
        apb(1'b1, `FOM_OFF_DEV, 32'h0123);
        apb(1'b1, `FOM_OFF_RAMP, 32'h09);
        pattern <= 8'hff;
        apb(1'b1, `FOM_OFF_MODE, 32'h6);
        cyc(20);
        chk("dev_plus", 32'h0123, {16'h0, synth});
        pattern <= 8'h00;
        cyc(20);
        chk("dev_minus", 32'hfedd, {16'h0, synth});
    endtask : t_dev

    task automatic t_rate;
        int c;
        apb(1'b1, `FOM_OFF_RATE_HIGH, 32'h0);
        apb(1'b1, `FOM_OFF_RATE_LOW, 32'h4);
        apb(1'b1, `FOM_OFF_RATE_FRAC, 32'h8);
        pattern <= 8'hff;
        align <= 1'b1;
        for (int s = 1; s <= 2; s++) begin
            apb(1'b1, `FOM_OFF_MODE, 32'h2);
            apb(1'b1, `FOM_OFF_RAMP, {26'h0, s[1:0], 4'h9});
            apb(1'b1, `FOM_OFF_MODE, 32'h6);
            meas(c);
            chk("fsk_two_bits", 32'd9, c);
            cyc(60);
            chk("gauss_settled", 32'h0123, {16'h0, synth});
        end
        apb(1'b1, `FOM_OFF_MODE, 32'h7);
        meas(c);
        chk("ook_two_bits", 32'd8, c);
    endtask : t_rate

    task automatic t_ook;
        logic mid;
        mid = 1'b0;
        align <= 1'b0;
        pattern <= 8'h00;
        apb(1'b1, `FOM_OFF_RAMP, 32'h19);
        cyc(40);
        chk("pa_off", 32'h0, {24'h0, pa});
        pattern <= 8'hff;
        for (int i = 0; i < 100 && pa !== 8'hff; i++) begin
            @(negedge sys_clk);
            if (pa !== 8'h00 && pa !== 8'hff)
                mid = 1'b1;
        end
        @(posedge sys_clk);
        chk("pa_on", 32'hff, {24'h0, pa});
        chk("pa_ramped", 32'h1, {31'h0, mid});
        pattern <= 8'h00;
        cyc(60);
        chk("pa_off_again", 32'h0, {24'h0, pa});
    endtask : t_ook

    task automatic rx_is(input string name, input logic [7:0] r, input logic exp);
        rssi <= r;
        cyc(2);
        apb(1'b0, `FOM_OFF_STATUS, 32'h0);
        chk(name, {31'h0, exp}, {31'h0, rd[17]});
    endtask : rx_is

    task automatic t_thr;
        apb(1'b1, `FOM_OFF_MODE, 32'h1);
        apb(1'b1, `FOM_OFF_PEAK, 32'h47);
        rx_is("peak_rx_one", 8'd200, 1'b1);
        chk("peak_load", 32'd200, {24'h0, rd[7:0]});
        rx_is("peak_above", 8'd190, 1'b1);
        rx_is("peak_below", 8'd186, 1'b0);
        apb(1'b1, `FOM_OFF_PEAK, 32'h40);
        rssi <= 8'h00;
        cyc(250);
        rchk("peak_floor", `FOM_OFF_STATUS, 32'h0c);
        apb(1'b1, `FOM_OFF_FLOOR, 32'h50);
        apb(1'b1, `FOM_OFF_PEAK, 32'h00);
        rx_is("fixed_one", 8'h60, 1'b1);
        rx_is("fixed_zero", 8'h40, 1'b0);
        apb(1'b1, `FOM_OFF_PEAK, 32'h80);
        cyc(100);
        rx_is("avg_zero", 8'h40, 1'b0);
        rx_is("avg_one", 8'hc0, 1'b1);
    endtask : t_thr

    task automatic t_sync;
        apb(1'b1, `FOM_OFF_PEAK, 32'h00);
        apb(1'b1, `FOM_OFF_MODE, 32'h9);
        rssi <= 8'hc0;
        cyc(40);
        @(negedge sys_clk);
        chk("sync_rx_one", 32'h1, {31'h0, dev_out});
        @(posedge sys_clk);
        rssi <= 8'h00;
        cyc(40);
        @(negedge sys_clk);
        chk("sync_rx_zero", 32'h0, {31'h0, dev_out});
        @(posedge sys_clk);
    endtask : t_sync

    initial begin
        cyc(16);
        rst_n <= 1'b1;
        cyc(1);
        t_regs();
        t_dev();
        t_rate();
        t_ook();
        t_thr();
        t_sync();
        results();
    end
endmodule : testbench
`default_nettype wire
